// >>> inc/touch_regs_cfg.svh
// Register offsets, field positions, reset values and key bytes for the readback bank
`ifndef TOUCH_REGS_CFG_SVH
`define TOUCH_REGS_CFG_SVH

`define ADDR_LOCK_OFS 8'h79
`define BUS_ADDRESS_PIN_MODE_OFS 8'h7C
`define SENSOR_READOUT_SELECT_OFS 8'h81
`define BASELINE_HIGH_OFS 8'h82
`define BASELINE_LOW_OFS 8'h83
`define DELTA_COUNT_HIGH_OFS 8'h84
`define DELTA_COUNT_LOW_OFS 8'h85
`define RAW_COUNT_HIGH_OFS 8'h86
`define RAW_COUNT_LOW_OFS 8'h87
`define TOUCH_ON_FLAGS_OFS 8'h88

`define PULLUP_DISABLE_BIT 7
`define READ_ENABLE_BIT 7

`define BUS_ADDRESS_PIN_MODE_RST 8'h00
`define SENSOR_READOUT_SELECT_RST 8'h00
`define LOCK_STATE_RST 1'b1

`define UNLOCK_KEY0 8'h3C
`define UNLOCK_KEY1 8'hA5
`define UNLOCK_KEY2 8'h69
`define LOCK_KEY0 8'h96
`define LOCK_KEY1 8'h5A
`define LOCK_KEY2 8'hC3

`endif

// >>> inc/touch_regs_pkg.sv
// Types shared by the touch sensor readback register bank
package touch_regs_pkg;

    typedef enum logic [1:0] {
        KEY_IDLE,
        KEY_ONE,
        KEY_TWO
    } key_phase_t;

endpackage : touch_regs_pkg

// >>> verilog/lock_sequencer.sv
// Three-byte unlock and lock key sequencer for the address lock
`timescale 1ns/1ps
`default_nettype none
`include "touch_regs_cfg.svh"

module lock_sequencer
    import touch_regs_pkg::*;
(
    // Clock and reset
    input wire logic clock_in,
    input wire logic rst_b_in,
    // Writes to the lock register
    input wire logic write_in,
    input wire logic [7:0] data_in,
    // State
    output logic locked_out,
    output logic relock_out
);

    typedef struct packed {
        key_phase_t unlock_phase;
        key_phase_t lock_phase;
        logic locked;
        logic relock;
    } seq_state_t;

    seq_state_t state_reg;
    seq_state_t state_next;

    // Each key chain restarts on any wrong byte; a wrong byte may itself start it
    always_comb begin
        state_next = state_reg;
        state_next.relock = 1'b0;
        if (write_in) begin
            unique case (state_reg.unlock_phase)
                KEY_IDLE: state_next.unlock_phase = (data_in == `UNLOCK_KEY0) ? KEY_ONE : KEY_IDLE;
                KEY_ONE: state_next.unlock_phase = (data_in == `UNLOCK_KEY1) ? KEY_TWO :
                    (data_in == `UNLOCK_KEY0) ? KEY_ONE : KEY_IDLE;
                KEY_TWO: begin
                    state_next.unlock_phase = (data_in == `UNLOCK_KEY0) ? KEY_ONE : KEY_IDLE;
                    if (data_in == `UNLOCK_KEY2) begin
                        state_next.locked = 1'b0;
                        state_next.unlock_phase = KEY_IDLE;
                    end
                end
                default: state_next.unlock_phase = KEY_IDLE;
            endcase
            unique case (state_reg.lock_phase)
                KEY_IDLE: state_next.lock_phase = (data_in == `LOCK_KEY0) ? KEY_ONE : KEY_IDLE;
                KEY_ONE: state_next.lock_phase = (data_in == `LOCK_KEY1) ? KEY_TWO :
                    (data_in == `LOCK_KEY0) ? KEY_ONE : KEY_IDLE;
                KEY_TWO: begin
                    state_next.lock_phase = (data_in == `LOCK_KEY0) ? KEY_ONE : KEY_IDLE;
                    if (data_in == `LOCK_KEY2) begin
                        state_next.locked = 1'b1;
                        state_next.relock = 1'b1;
                        state_next.lock_phase = KEY_IDLE;
                    end
                end
                default: state_next.lock_phase = KEY_IDLE;
            endcase
        end
    end

    always_ff @(posedge clock_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            state_reg <= '{KEY_IDLE, KEY_IDLE, `LOCK_STATE_RST, 1'b0};
        end else begin
            state_reg <= state_next;
        end
    end

    assign locked_out = state_reg.locked;
    assign relock_out = state_reg.relock;

endmodule : lock_sequencer
`default_nettype wire

// >>> verilog/input_selector.sv
// Readout input select register with one-hot and sensing-pin checks
`timescale 1ns/1ps
`default_nettype none
`include "touch_regs_cfg.svh"

module input_selector
    import touch_regs_pkg::*;
#(
    parameter int NUM_INPUTS = 2
) (
    // Clock and reset
    input wire logic clock_in,
    input wire logic rst_b_in,
    // Write port and pin configuration
    input wire logic write_in,
    input wire logic [7:0] data_in,
    input wire logic [NUM_INPUTS-1:0] sensing_pins_in,
    // Register contents
    output logic [7:0] select_out
);

    typedef struct packed {
        logic [7:0] select;
    } sel_state_t;

    sel_state_t state_reg;
    sel_state_t state_next;

    function automatic logic one_hot(input logic [NUM_INPUTS-1:0] mask);
        return (mask != '0) && ((mask & (mask - 1'b1)) == '0);
    endfunction : one_hot

    logic [NUM_INPUTS-1:0] mask_w;
    assign mask_w = data_in[NUM_INPUTS-1:0];

    // Rejected writes leave both the old input and the enable untouched
    always_comb begin
        state_next = state_reg;
        if (write_in && one_hot(mask_w)
            && ((mask_w & ~sensing_pins_in) == '0)) begin
            state_next.select = 8'h00;
            state_next.select[`READ_ENABLE_BIT] = data_in[`READ_ENABLE_BIT];
            state_next.select[NUM_INPUTS-1:0] = mask_w;
        end
    end

    always_ff @(posedge clock_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            state_reg <= '{`SENSOR_READOUT_SELECT_RST};
        end else begin
            state_reg <= state_next;
        end
    end

    assign select_out = state_reg.select;

endmodule : input_selector
`default_nettype wire

// >>> verilog/touch_sensor_readback_regs.sv
// Touch sensor readback register bank on the device's serial register port
`timescale 1ns/1ps
`default_nettype none
`include "touch_regs_cfg.svh"

module touch_sensor_readback_regs
    import touch_regs_pkg::*;
#(
    parameter int NUM_INPUTS = 2
) (
    // Clock and reset
    input wire logic clock_in,
    input wire logic rst_b_in,
    // Register port from the serial slave
    input wire logic reg_write_in,
    input wire logic reg_read_in,
    input wire logic [7:0] reg_addr_in,
    input wire logic [7:0] reg_wdata_in,
    output logic [7:0] reg_rdata_out,
    output logic reg_rvalid_out,
    // Sensing core results
    input wire logic [NUM_INPUTS-1:0] sensing_pins_in,
    input wire logic [NUM_INPUTS*16-1:0] baseline_value_in,
    input wire logic [NUM_INPUTS*16-1:0] delta_count_in,
    input wire logic [NUM_INPUTS*16-1:0] raw_count_in,
    input wire logic [NUM_INPUTS-1:0] touch_on_flags_in,
    // Applied bus configuration
    output logic [6:0] slave_address_out,
    output logic pin_pullup_disable_out
);

    // ************************************************************
    // Reset release
    // ************************************************************
    logic [1:0] rst_sync_reg;
    logic rst_b;

    always_ff @(posedge clock_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            rst_sync_reg <= 2'b00;
        end else begin
            rst_sync_reg <= {rst_sync_reg[0], 1'b1};
        end
    end
    assign rst_b = rst_sync_reg[1];

    // ************************************************************
    // Lock and selection submodules
    // ************************************************************
    logic address_lock_state;
    logic relock;
    logic [7:0] select_reg_w;
    logic lock_wr;
    logic address_wr;
    logic select_wr;

    // Write strobe decode, shared by the instances and the checks
    function automatic logic wr_hit(input logic we, input logic [7:0] addr,
        input logic [7:0] ofs);
        return we && addr == ofs;
    endfunction : wr_hit

    assign lock_wr = wr_hit(reg_write_in, reg_addr_in, `ADDR_LOCK_OFS);
    assign address_wr = wr_hit(reg_write_in, reg_addr_in, `BUS_ADDRESS_PIN_MODE_OFS);
    assign select_wr = wr_hit(reg_write_in, reg_addr_in, `SENSOR_READOUT_SELECT_OFS);

    lock_sequencer lock_u (
        .clock_in(clock_in),
        .rst_b_in(rst_b),
        .write_in(lock_wr),
        .data_in(reg_wdata_in),
        .locked_out(address_lock_state),
        .relock_out(relock)
    );

    input_selector #(.NUM_INPUTS(NUM_INPUTS)) select_u (
        .clock_in(clock_in),
        .rst_b_in(rst_b),
        .write_in(select_wr),
        .data_in(reg_wdata_in),
        .sensing_pins_in(sensing_pins_in),
        .select_out(select_reg_w)
    );

    // ************************************************************
    // Selected input results
    // ************************************************************
    logic [15:0] sel_base;
    logic [15:0] sel_delta;
    logic [15:0] sel_raw;

    // One-hot mux; an empty mask yields zero
    always_comb begin
        sel_base = 16'h0000;
        sel_delta = 16'h0000;
        sel_raw = 16'h0000;
        for (int i = 0; i < NUM_INPUTS; i++) begin
            if (select_reg_w[i]) begin
                sel_base = baseline_value_in[i*16 +: 16];
                sel_delta = delta_count_in[i*16 +: 16];
                sel_raw = raw_count_in[i*16 +: 16];
            end
        end
    end

    // ************************************************************
    // Register state
    // ************************************************************
    typedef struct packed {
        logic [7:0] pending_addr;
        logic [7:0] applied_addr;
        logic [7:0] rdata;
        logic rvalid;
        logic [15:0] key_hist;
    } bank_state_t;

    bank_state_t state_reg;
    bank_state_t state_next;
    logic rd_en;

    assign rd_en = select_reg_w[`READ_ENABLE_BIT];

    always_comb begin
        state_next = state_reg;
        state_next.rvalid = reg_read_in;
        if (address_wr
            && !address_lock_state) begin
            state_next.pending_addr = reg_wdata_in;
        end
        // Applying only on relock avoids dropping the link mid-transaction
        if (relock) begin
            state_next.applied_addr = state_reg.pending_addr;
        end
        // Last two lock bytes, kept only so the key chain checks can see them
        if (lock_wr) begin
            state_next.key_hist = {state_reg.key_hist[7:0], reg_wdata_in};
        end
        if (reg_read_in) begin
            state_next.rdata = 8'h00;
            unique case (reg_addr_in)
                `ADDR_LOCK_OFS: state_next.rdata = {7'h00, address_lock_state};
                `BUS_ADDRESS_PIN_MODE_OFS: state_next.rdata = state_reg.pending_addr;
                `SENSOR_READOUT_SELECT_OFS: state_next.rdata = select_reg_w;
                `BASELINE_HIGH_OFS: state_next.rdata = rd_en ? sel_base[15:8] : 8'h00;
                `BASELINE_LOW_OFS: state_next.rdata = rd_en ? sel_base[7:0] : 8'h00;
                `DELTA_COUNT_HIGH_OFS: state_next.rdata = rd_en ? sel_delta[15:8] : 8'h00;
                `DELTA_COUNT_LOW_OFS: state_next.rdata = rd_en ? sel_delta[7:0] : 8'h00;
                `RAW_COUNT_HIGH_OFS: state_next.rdata = rd_en ? sel_raw[15:8] : 8'h00;
                `RAW_COUNT_LOW_OFS: state_next.rdata = rd_en ? sel_raw[7:0] : 8'h00;
                `TOUCH_ON_FLAGS_OFS: begin
                    state_next.rdata[NUM_INPUTS-1:0] = touch_on_flags_in;
                end
                default: state_next.rdata = 8'h00;
            endcase
        end
    end

    always_ff @(posedge clock_in or negedge rst_b) begin
        if (!rst_b) begin
            state_reg <= '{`BUS_ADDRESS_PIN_MODE_RST, `BUS_ADDRESS_PIN_MODE_RST,
                8'h00, 1'b0, 16'h0000};
        end else begin
            state_reg <= state_next;
        end
    end

    assign reg_rdata_out = state_reg.rdata;
    assign reg_rvalid_out = state_reg.rvalid;
    assign slave_address_out = state_reg.applied_addr[6:0];
    assign pin_pullup_disable_out = state_reg.applied_addr[`PULLUP_DISABLE_BIT];

    // ************************************************************
    // Checks
    // ************************************************************
    locked_write_a: assert property (@(posedge clock_in) disable iff (!rst_b)
        reg_write_in && reg_addr_in == `BUS_ADDRESS_PIN_MODE_OFS && address_lock_state
        |=> $stable(state_reg.pending_addr))
        else $error("address register changed while locked");
    apply_relock_a: assert property (@(posedge clock_in) disable iff (!rst_b)
        !relock |=> $stable({pin_pullup_disable_out, slave_address_out}))
        else $error("bus address changed without relock");
    pullup_bit_a: assert property (@(posedge clock_in) disable iff (!rst_b)
        relock |=> pin_pullup_disable_out == $past(state_reg.pending_addr[7]))
        else $error("pull-up mode not taken from bit 7");
    address_bits_a: assert property (@(posedge clock_in) disable iff (!rst_b)
        relock |=> slave_address_out == $past(state_reg.pending_addr[6:0]))
        else $error("slave address not taken from bits 6:0");
    select_onehot_a: assert property (@(posedge clock_in) disable iff (!rst_b)
        $countones(select_reg_w[NUM_INPUTS-1:0]) <= 1)
        else $error("select mask not one-hot");
    readout_gate_a: assert property (@(posedge clock_in) disable iff (!rst_b)
        reg_read_in && !rd_en
        && reg_addr_in inside {[`BASELINE_HIGH_OFS:`RAW_COUNT_LOW_OFS]}
        |=> reg_rdata_out == 8'h00)
        else $error("result read while disabled");
    baseline_high_a: assert property (@(posedge clock_in) disable iff (!rst_b)
        reg_read_in && rd_en && reg_addr_in == `BASELINE_HIGH_OFS
        |=> reg_rvalid_out && reg_rdata_out == $past(sel_base[15:8]))
        else $error("baseline high byte wrong");
    lock_read_a: assert property (@(posedge clock_in) disable iff (!rst_b)
        reg_read_in && reg_addr_in == `ADDR_LOCK_OFS
        |=> reg_rdata_out == {7'h00, $past(address_lock_state)})
        else $error("lock state readback wrong");
    status_read_a: assert property (@(posedge clock_in) disable iff (!rst_b)
        reg_read_in && reg_addr_in == `TOUCH_ON_FLAGS_OFS
        |=> reg_rdata_out[NUM_INPUTS-1:0] == $past(touch_on_flags_in))
        else $error("touch flags readback wrong");

    // ************************************************************
    // Checks on the shared clock
    // ************************************************************
    default clocking chk_cb @(posedge clock_in);
    endclocking
    default disable iff (!rst_b);

    // Key history tells a full chain from a restarted one
    unlock_key_a: assert property (lock_wr && reg_wdata_in == `UNLOCK_KEY2
        && state_reg.key_hist == {`UNLOCK_KEY0, `UNLOCK_KEY1} |=> !address_lock_state)
        else $error("unlock key chain did not unlock");

    lock_key_a: assert property (lock_wr && reg_wdata_in == `LOCK_KEY2
        && state_reg.key_hist == {`LOCK_KEY0, `LOCK_KEY1} |=> address_lock_state && relock)
        else $error("lock key chain did not lock");

    lock_hold_a: assert property (!lock_wr |=> $stable(address_lock_state))
        else $error("lock state moved without a key byte");

    pending_write_a: assert property (address_wr && !address_lock_state
        |=> state_reg.pending_addr == $past(reg_wdata_in))
        else $error("unlocked address write lost");

    pending_hold_a: assert property (!address_wr
        |=> $stable(state_reg.pending_addr))
        else $error("address register changed without a write");

    address_read_a: assert property (reg_read_in
        && reg_addr_in == `BUS_ADDRESS_PIN_MODE_OFS
        |=> reg_rdata_out == $past(state_reg.pending_addr))
        else $error("address register readback wrong");

    multi_select_a: assert property (select_wr
        && $countones(reg_wdata_in[NUM_INPUTS-1:0]) > 1 |=> $stable(select_reg_w))
        else $error("multi-bit select accepted");

    pin_select_a: assert property (select_wr
        && (reg_wdata_in[NUM_INPUTS-1:0] & ~sensing_pins_in) != '0
        |=> $stable(select_reg_w))
        else $error("non-sensing pin selected");

    // An empty mask is refused too, so results never go dark by accident
    keep_select_a: assert property (select_wr
        && $countones(reg_wdata_in[NUM_INPUTS-1:0]) != 1 |=> $stable(select_reg_w))
        else $error("rejected select changed the input");

    select_idle_a: assert property (!select_wr
        |=> $stable(select_reg_w))
        else $error("select changed without a write");

    select_accept_a: assert property (select_wr
        && $countones(reg_wdata_in[NUM_INPUTS-1:0]) == 1
        && (reg_wdata_in[NUM_INPUTS-1:0] & ~sensing_pins_in) == '0
        |=> rd_en == $past(reg_wdata_in[`READ_ENABLE_BIT])
        && select_reg_w[NUM_INPUTS-1:0] == $past(reg_wdata_in[NUM_INPUTS-1:0]))
        else $error("valid select write not stored");

    select_read_a: assert property (reg_read_in
        && reg_addr_in == `SENSOR_READOUT_SELECT_OFS
        |=> reg_rdata_out == $past(select_reg_w))
        else $error("select register readback wrong");

    generate
        for (genvar g = 0; g < NUM_INPUTS; g++) begin : g_sel_chk
            sel_input_a: assert property (@(posedge clock_in) disable iff (!rst_b)
                select_reg_w[g] |-> sel_base == baseline_value_in[g*16 +: 16]
                && sel_delta == delta_count_in[g*16 +: 16]
                && sel_raw == raw_count_in[g*16 +: 16])
                else $error("results not from the selected input");
        end
    endgenerate

    // Bytes are live, not latched in pairs, so each byte is checked alone
    baseline_low_a: assert property (reg_read_in && rd_en
        && reg_addr_in == `BASELINE_LOW_OFS |=> reg_rdata_out == $past(sel_base[7:0]))
        else $error("baseline low byte wrong");

    delta_high_a: assert property (reg_read_in && rd_en
        && reg_addr_in == `DELTA_COUNT_HIGH_OFS |=> reg_rdata_out == $past(sel_delta[15:8]))
        else $error("difference high byte wrong");

    delta_low_a: assert property (reg_read_in && rd_en
        && reg_addr_in == `DELTA_COUNT_LOW_OFS |=> reg_rdata_out == $past(sel_delta[7:0]))
        else $error("difference low byte wrong");

    raw_high_a: assert property (reg_read_in && rd_en
        && reg_addr_in == `RAW_COUNT_HIGH_OFS |=> reg_rdata_out == $past(sel_raw[15:8]))
        else $error("raw count high byte wrong");

    raw_low_a: assert property (reg_read_in && rd_en
        && reg_addr_in == `RAW_COUNT_LOW_OFS |=> reg_rdata_out == $past(sel_raw[7:0]))
        else $error("raw count low byte wrong");

    status_upper_a: assert property (reg_read_in
        && reg_addr_in == `TOUCH_ON_FLAGS_OFS |=> reg_rdata_out[7:NUM_INPUTS] == '0)
        else $error("touch flags upper bits not zero");

    unmapped_read_a: assert property (reg_read_in
        && reg_addr_in > `TOUCH_ON_FLAGS_OFS |=> reg_rdata_out == 8'h00)
        else $error("unmapped read not zero");

    read_pulse_a: assert property (reg_read_in |=> reg_rvalid_out)
        else $error("read answer missing");

    read_idle_a: assert property (!reg_read_in |=> !reg_rvalid_out)
        else $error("read answer without a read");

    rdata_hold_a: assert property (!reg_read_in |=> $stable(reg_rdata_out))
        else $error("read data moved without a read");

    // ************************************************************
    // Coverage
    // ************************************************************
    unlock_seen_c: cover property (@(posedge clock_in) disable iff (!rst_b)
        $fell(address_lock_state));
    relock_seen_c: cover property (@(posedge clock_in) disable iff (!rst_b) relock);
    result_read_c: cover property (@(posedge clock_in) disable iff (!rst_b)
        reg_read_in && rd_en && reg_addr_in == `DELTA_COUNT_LOW_OFS);
    reject_seen_c: cover property (select_wr
        && $countones(reg_wdata_in[NUM_INPUTS-1:0]) > 1);
    gated_read_c: cover property (reg_read_in && !rd_en
        && reg_addr_in == `RAW_COUNT_HIGH_OFS);

endmodule : touch_sensor_readback_regs
`default_nettype wire

// >>> verification/sensing_core_model.sv
// Behavioural sensing core supplying scan results and touch state
`timescale 1ns/1ps
`default_nettype none

module sensing_core_model #(
    parameter int NUM_INPUTS = 2
) (
    // Clock and load
    input wire logic clock_in,
    input wire logic load_in,
    input wire logic [31:0] seed_in,
    // Scan results
    output logic [NUM_INPUTS*16-1:0] baseline_value_out,
    output logic [NUM_INPUTS*16-1:0] delta_count_out,
    output logic [NUM_INPUTS*16-1:0] raw_count_out,
    output logic [NUM_INPUTS-1:0] touch_on_flags_out
);
    // ****************************************
    // Scan update
    // ****************************************
    // Values move only on load, so the bench can predict every byte
    always_ff @(posedge clock_in) begin
        if (load_in) begin
            for (int i = 0; i < NUM_INPUTS; i++) begin
                baseline_value_out[i*16+:16] <= seed_in[15:0] ^ 16'(i * 16'h1111);
                delta_count_out[i*16+:16] <= seed_in[31:16] ^ 16'(i * 16'h2222);
                raw_count_out[i*16+:16] <= ~seed_in[15:0] ^ 16'(i * 16'h0F0F);
            end
            touch_on_flags_out <= seed_in[NUM_INPUTS+3:4];
        end
    end
endmodule : sensing_core_model
`default_nettype wire

// >>> verification/touch_sensor_readback_regs_test.sv
// Self-checking bench for the touch sensor readback register bank
`timescale 1ns/1ps
`default_nettype none
`include "touch_regs_cfg.svh"

module touch_sensor_readback_regs_test;
    logic clock_in = 1'b0;
    logic rst_b_in = 1'b0;
    logic wr_en = 1'b0;
    logic rd_en = 1'b0;
    logic load = 1'b0;
    logic [7:0] addr = 8'h00;
    logic [7:0] wdata = 8'h00;
    logic [1:0] pins = 2'b11;
    logic [31:0] seed = 32'h4D35;
    logic [31:0] rnd = 32'h4D35;
    logic [7:0] rdata;
    logic rvalid;
    logic [6:0] slave_addr;
    logic pullup_off;
    logic [31:0] bl;
    logic [31:0] dc;
    logic [31:0] rc;
    logic [1:0] flags;
    logic [7:0] newv;
    logic [7:0] exp_q[$];
    string name_q[$];
    int bad_count = 0;
    int n_checks = 0;

    sensing_core_model u_sensing_core_model (.clock_in(clock_in), .load_in(load),
        .seed_in(seed), .baseline_value_out(bl), .delta_count_out(dc),
        .raw_count_out(rc), .touch_on_flags_out(flags));

    touch_sensor_readback_regs u_touch_sensor_readback_regs (.clock_in(clock_in),
        .rst_b_in(rst_b_in), .reg_write_in(wr_en), .reg_read_in(rd_en),
        .reg_addr_in(addr), .reg_wdata_in(wdata), .reg_rdata_out(rdata),
        .reg_rvalid_out(rvalid), .sensing_pins_in(pins), .baseline_value_in(bl),
        .delta_count_in(dc), .raw_count_in(rc), .touch_on_flags_in(flags),
        .slave_address_out(slave_addr), .pin_pullup_disable_out(pullup_off));

    initial begin
        forever #5 clock_in = ~clock_in;
    end

    // ****************************************
    // Helpers
    // ****************************************
    function automatic logic [31:0] lfsr(input logic [31:0] x);
        return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
    endfunction : lfsr

    function automatic logic [15:0] mv(input int k, input int i);
        case (k)
            0: return seed[15:0] ^ 16'(i * 16'h1111);
            1: return seed[31:16] ^ 16'(i * 16'h2222);
            default: return ~seed[15:0] ^ 16'(i * 16'h0F0F);
        endcase
    endfunction : mv

    task automatic check(input string n, input logic [7:0] e, input logic [7:0] s);
        n_checks++;
        if (s !== e) begin
            bad_count++;
            $display("[FAIL] %s expected %h seen %h", n, e, s);
        end
    endtask : check

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clock_in);
        #1;
        addr = a;
        wdata = d;
        wr_en = 1'b1;
        @(posedge clock_in);
        #1;
        wr_en = 1'b0;
    endtask : wr

    task automatic rd(input logic [7:0] a, input logic [7:0] e, input string n);
        exp_q.push_back(e);
        name_q.push_back(n);
        @(posedge clock_in);
        #1;
        addr = a;
        rd_en = 1'b1;
        @(posedge clock_in);
        #1;
        rd_en = 1'b0;
    endtask : rd

    task automatic wr3(input logic [7:0] a, input logic [7:0] b, input logic [7:0] c);
        wr(`ADDR_LOCK_OFS, a);
        wr(`ADDR_LOCK_OFS, b);
        wr(`ADDR_LOCK_OFS, c);
    endtask : wr3

    task automatic rd_all(input int i);
        for (int k = 0; k < 3; k++) begin
            rd(8'(`BASELINE_HIGH_OFS + 2 * k), 8'(mv(k, i) >> 8), "result_high");
            rd(8'(`BASELINE_LOW_OFS + 2 * k), 8'(mv(k, i)), "result_low");
        end
        rd(`TOUCH_ON_FLAGS_OFS, {6'h00, seed[5:4]}, "touch_flags");
    endtask : rd_all

    task automatic print_verdict;
        // A read that never answered must not slip through as a pass
        if (exp_q.size() != 0) begin
            bad_count++;
            $display("[FAIL] pending_reads expected %0d seen %0d", 0, exp_q.size());
        end
        $display("checks %0d mismatches %0d", n_checks, bad_count);
        if (bad_count == 0 && n_checks > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask : print_verdict

    // ****************************************
    // Read monitor
    // ****************************************
    always @(posedge clock_in) begin
        if (rvalid === 1'b1) begin
            if (exp_q.size() == 0) begin
                check("unexpected_read", 8'h00, 8'hXX);
            end else begin
                check(name_q.pop_front(), exp_q.pop_front(), rdata);
            end
        end
    end

    // ****************************************
    // Tests
    // ****************************************
    initial begin
        load = 1'b1;
        repeat (8) @(posedge clock_in);
        #1;
        load = 1'b0;
        rst_b_in = 1'b1;
        repeat (3) @(posedge clock_in);
        rd(`ADDR_LOCK_OFS, 8'h01, "lock_reset");
        rd(`BUS_ADDRESS_PIN_MODE_OFS, 8'h00, "addr_reset");
        rd(`SENSOR_READOUT_SELECT_OFS, 8'h00, "select_reset");
        rd(`BASELINE_HIGH_OFS, 8'h00, "result_gated");
        rd(8'h90, 8'h00, "unmapped");
        $display("reset test done");
        rnd = lfsr(lfsr(rnd));
        newv = rnd[7:0];
        wr(`BUS_ADDRESS_PIN_MODE_OFS, newv);
        rd(`BUS_ADDRESS_PIN_MODE_OFS, 8'h00, "locked_write");
        wr3(`UNLOCK_KEY0, `UNLOCK_KEY1, `UNLOCK_KEY2);
        rd(`ADDR_LOCK_OFS, 8'h00, "unlocked");
        wr(`BUS_ADDRESS_PIN_MODE_OFS, newv);
        rd(`BUS_ADDRESS_PIN_MODE_OFS, newv, "pending");
        check("addr_before_lock", 8'h00, {pullup_off, slave_addr});
        wr3(`LOCK_KEY0, `LOCK_KEY1, `LOCK_KEY2);
        rd(`ADDR_LOCK_OFS, 8'h01, "relocked");
        repeat (2) @(posedge clock_in);
        #1;
        check("slave_address", {1'b0, newv[6:0]}, {1'b0, slave_addr});
        check("pullup_disable", {7'h00, newv[7]}, {7'h00, pullup_off});
        $display("address lock test done");
        // Two fresh scans so stale values cannot pass
        repeat (2) begin
            rnd = lfsr(rnd);
            seed = rnd;
            load = 1'b1;
            @(posedge clock_in);
            #1;
            load = 1'b0;
            for (int i = 0; i < 2; i++) begin
                wr(`SENSOR_READOUT_SELECT_OFS, 8'h80 | 8'(1 << i));
                rd_all(i);
            end
        end
        wr(`SENSOR_READOUT_SELECT_OFS, 8'h83);
        rd(`SENSOR_READOUT_SELECT_OFS, 8'h82, "multi_bit");
        rd_all(1);
        pins = 2'b10;
        wr(`SENSOR_READOUT_SELECT_OFS, 8'h81);
        rd(`SENSOR_READOUT_SELECT_OFS, 8'h82, "non_sensing");
        pins = 2'b11;
        wr(`SENSOR_READOUT_SELECT_OFS, 8'h01);
        rd(`RAW_COUNT_HIGH_OFS, 8'h00, "read_disabled");
        repeat (3) @(posedge clock_in);
        $display("selection test done");
        print_verdict();
    end

    initial begin
        #50000;
        bad_count++;
        print_verdict();
    end
endmodule : touch_sensor_readback_regs_test
`default_nettype wire
